// ---- verilog/tsr_regs.vh ----
`ifndef TSR_REGS_VH
`define TSR_REGS_VH
// Primary byte 0 condition bits
`define TSR_B0_FILE_MARK    0
`define TSR_B0_NO_BLOCK     1
`define TSR_B0_DATA_ERR     2
`define TSR_B0_END_MEDIA    3
`define TSR_B0_WR_PROT      4
`define TSR_B0_OFFLINE      5
`define TSR_B0_NO_CART      6
`define TSR_SUMMARY_BIT     7
// Primary byte 1 condition bits
`define TSR_B1_RESET_SEEN   0
`define TSR_B1_FAULT        1
`define TSR_B1_PARITY       2
`define TSR_B1_BEGIN_MEDIA  3
`define TSR_B1_MARGINAL     4
`define TSR_B1_NO_DATA      5
`define TSR_B1_ILLEGAL_CMD  6
// Extended byte 0 flag bits (bit 0 unused)
`define TSR_X0_NO_ERASE     1
`define TSR_X0_LEADER       2
`define TSR_X0_TIMEOUT      3
`define TSR_X0_REPOS        4
`define TSR_X0_BUF_ERR      5
`define TSR_X0_RAM_ERR      6
`define TSR_X0_ROM_ERR      7
// Byte counts and resets
`define TSR_PRI_BYTES       3'd6
`define TSR_EXT_BYTES       3'd5
`define TSR_LAST_PRI        3'd5
`define TSR_LAST_EXT        3'd4
`define TSR_CNT_RST         16'h0000
`define TSR_FLAGS_RST       7'h00
`define TSR_B1_RST          7'h01
`endif

// ---- verilog/tsr_sat_counter.v ----
`timescale 1ns/1ps
`include "tsr_regs.vh"
// 16-bit event counter; holds at full scale rather than wrapping
module tsr_sat_counter (
  input  wire        mclk,   // Clock
  input  wire        srst,   // Sync reset
  input  wire        inc,    // Count pulse
  output reg  [15:0] count   // Count value
);
  always @(posedge mclk) begin
    if (srst) begin
      // A pulse in the clearing cycle still counts
      count <= `TSR_CNT_RST | {15'h0000, inc};
    end else if (inc && count != 16'hffff) begin
      count <= count + 16'h0001;
    end
  end
endmodule

// ---- verilog/tsr_byte_mux.v ----
`timescale 1ns/1ps
// Selects one byte of an up-to-six-byte report
module tsr_byte_mux (
  input  wire [47:0] report, // Bytes, byte 0 in [7:0]
  input  wire [2:0]  sel,    // Byte index
  output reg  [7:0]  data    // Selected byte
);
  always @* begin
    case (sel)
      3'd0:    data = report[7:0];
      3'd1:    data = report[15:8];
      3'd2:    data = report[23:16];
      3'd3:    data = report[31:24];
      3'd4:    data = report[39:32];
      3'd5:    data = report[47:40];
      default: data = 8'h00;
    endcase
  end
endmodule

// ---- verilog/tsr_top.v ----
`timescale 1ns/1ps
`include "tsr_regs.vh"
// Summary of operation
// - Byte 0 bits 0-6: file mark, no block, data error, end, protect, offline, no cart.
// - Byte 0 bit 7 set whenever any byte 0 condition bit is set.
// - Byte 1 bits 0-3: reset seen, internal fault, bus parity, beginning of media.
// - Byte 1 bits 4-6: marginal block on write retry, no data, illegal command.
// - Byte 1 bit 7 set whenever any other byte 1 bit is set.
// - Data error counter, bytes 2 (high) and 3 (low), counts rewrites and retries.
// - Underrun/overrun counter, bytes 4 (high) and 5 (low), counts slow host transfers.
// - Extended byte 0: unused bit plus seven fault flags.
// - Extended byte 1: drive 0, drive 1, upper bits mean no drive selected.
// - Extended byte 2: track in bits 1-0, upper bits mean no track.
// - Extended bytes 3 and 4: current block number high then low.
module tsr_top (
  input  wire        mclk,          // 10 MHz clock
  input  wire        srst,          // Sync reset, active high
  input  wire [6:0]  pri0_set,      // Byte 0 condition set pulses
  input  wire [6:0]  pri1_set,      // Byte 1 condition set pulses
  input  wire [6:0]  ext0_set,      // Extended fault set pulses, bits 7-1
  input  wire        data_retry,    // Pulse per rewrite or read retry
  input  wire        stream_miss,   // Pulse per underrun or overrun
  input  wire        drive0_sel,    // Drive 0 selected level
  input  wire        drive1_sel,    // Drive 1 selected level
  input  wire        track_valid,   // A track is selected
  input  wire [1:0]  track_num,     // Selected track
  input  wire [15:0] block_num,     // Current block number
  input  wire        flags_clr,     // Clear all flags and counters
  input  wire        req_pri,       // Start primary report
  input  wire        req_ext,       // Start extended report
  input  wire        byte_ack,      // Host took the offered byte
  output reg  [7:0]  stat_data,     // Offered status byte
  output reg         stat_valid,    // Byte offered
  output reg         stat_last,     // Offered byte is final
  output reg         stat_busy      // Report in progress
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PRI  = 3'b010;
  localparam [2:0] ST_EXT  = 3'b100;

  reg  [6:0]  pri0_reg;
  reg  [6:0]  pri1_reg;
  reg  [6:0]  ext0_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  idx_reg;
  wire [15:0] data_err_cnt;
  wire [15:0] stream_cnt;
  wire [7:0]  byte0;
  wire [7:0]  byte1;
  wire [7:0]  xbyte0;
  wire [7:0]  xbyte1;
  wire [7:0]  xbyte2;
  wire [47:0] pri_report;
  wire [47:0] ext_report;
  wire [7:0]  pri_byte;
  wire [7:0]  ext_byte;
  wire        cnt_rst;
  wire        take;
  reg  [2:0]  idx_next;

  assign cnt_rst = srst | flags_clr;

  // Sticky flags; set beats a simultaneous clear
  always @(posedge mclk) begin
    if (srst) begin
      pri0_reg <= `TSR_FLAGS_RST;
      pri1_reg <= `TSR_B1_RST;
      ext0_reg <= `TSR_FLAGS_RST;
    end else if (flags_clr) begin
      pri0_reg <= pri0_set;
      pri1_reg <= pri1_set;
      ext0_reg <= ext0_set;
    end else begin
      pri0_reg <= pri0_reg | pri0_set;
      pri1_reg <= pri1_reg | pri1_set;
      ext0_reg <= ext0_reg | ext0_set;
    end
  end

  tsr_sat_counter u_data_err (
    .mclk  (mclk),
    .srst  (cnt_rst),
    .inc   (data_retry & ~srst),
    .count (data_err_cnt)
  );

  tsr_sat_counter u_stream (
    .mclk  (mclk),
    .srst  (cnt_rst),
    .inc   (stream_miss & ~srst),
    .count (stream_cnt)
  );

  assign byte0  = {|pri0_reg, pri0_reg};
  assign byte1  = {|pri1_reg, pri1_reg};
  assign xbyte0 = {ext0_reg, 1'b0};
  assign xbyte1 = {{6{~(drive0_sel | drive1_sel)}}, drive1_sel, drive0_sel};
  assign xbyte2 = {{6{~track_valid}}, track_num};

  assign pri_report = {stream_cnt[7:0], stream_cnt[15:8],
                       data_err_cnt[7:0], data_err_cnt[15:8],
                       byte1, byte0};
  assign ext_report = {8'h00, block_num[7:0], block_num[15:8],
                       xbyte2, xbyte1, xbyte0};

  tsr_byte_mux u_pri_mux (
    .report (pri_report),
    .sel    (idx_next),
    .data   (pri_byte)
  );

  tsr_byte_mux u_ext_mux (
    .report (ext_report),
    .sel    (idx_next),
    .data   (ext_byte)
  );

  assign take = stat_valid & byte_ack;

  always @* begin
    idx_next = 3'd0;
    if (state_reg != ST_IDLE && take) begin
      idx_next = idx_reg + 3'd1;
    end else if (state_reg != ST_IDLE) begin
      idx_next = idx_reg;
    end
  end

  // Byte sequencer; next byte only after the current one is accepted
  always @(posedge mclk) begin
    if (srst) begin
      state_reg  <= ST_IDLE;
      idx_reg    <= 3'd0;
      stat_data  <= 8'h00;
      stat_valid <= 1'b0;
      stat_last  <= 1'b0;
      stat_busy  <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          idx_reg    <= 3'd0;
          stat_valid <= 1'b0;
          stat_last  <= 1'b0;
          if (req_pri) begin
            state_reg  <= ST_PRI;
            stat_data  <= pri_byte;
            stat_valid <= 1'b1;
            stat_busy  <= 1'b1;
          end else if (req_ext) begin
            state_reg  <= ST_EXT;
            stat_data  <= ext_byte;
            stat_valid <= 1'b1;
            stat_busy  <= 1'b1;
          end
        end
        ST_PRI, ST_EXT: begin
          if (take) begin
            if (stat_last) begin
              state_reg  <= ST_IDLE;
              stat_valid <= 1'b0;
              stat_last  <= 1'b0;
              stat_busy  <= 1'b0;
              idx_reg    <= 3'd0;
            end else begin
              idx_reg   <= idx_next;
              stat_data <= (state_reg == ST_PRI) ? pri_byte : ext_byte;
              stat_last <= (state_reg == ST_PRI) ? (idx_next == `TSR_LAST_PRI)
                                                 : (idx_next == `TSR_LAST_EXT);
            end
          end
        end
        default: begin
          state_reg  <= ST_IDLE;
          stat_valid <= 1'b0;
          stat_busy  <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- tb/tsr_properties.sv ----
`timescale 1ns/1ps
module tsr_properties (
  input wire        mclk,        // Clock
  input wire        srst,        // Reset
  input wire        req_pri,     // Primary req
  input wire        byte_ack,    // Ack
  input wire        drive0_sel,  // Drive 0
  input wire        drive1_sel,  // Drive 1
  input wire        track_valid, // Track valid
  input wire [1:0]  track_num,   // Track
  input wire [15:0] block_num,   // Block
  input wire [7:0]  stat_data,   // Byte
  input wire        stat_valid,  // Offered
  input wire        stat_last,   // Final
  input wire        stat_busy    // Busy
);
  reg [2:0] idx_reg;
  reg       pri_reg;
  wire      ext_on = stat_valid && !pri_reg;
  // Byte index of the running report
  always @(posedge mclk) begin
    if (srst || !stat_busy)
      idx_reg <= 3'h0;
    else if (stat_valid && byte_ack)
      idx_reg <= idx_reg + 3'h1;
    if (!stat_busy)
      pri_reg <= req_pri;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  AST_START: assert property (req_pri && !stat_busy |=> stat_valid && stat_busy)
    else $error("no first byte");
  AST_HOLD: assert property (stat_valid && !byte_ack |=> stat_valid)
    else $error("byte dropped");
  AST_LAST: assert property (stat_valid |-> stat_last == (idx_reg == (pri_reg ? 3'h5 : 3'h4)))
    else $error("last flag wrong");
  AST_END: assert property (stat_valid && byte_ack && stat_last |=> !stat_valid && !stat_busy)
    else $error("no end");
  AST_SUM: assert property (stat_valid && pri_reg && idx_reg < 3'h2 |-> stat_data[7] == |stat_data[6:0])
    else $error("summary bit wrong");
  AST_DRV: assert property (ext_on && idx_reg == 3'h1 |-> stat_data == {{6{!(drive0_sel || drive1_sel)}}, drive1_sel, drive0_sel})
    else $error("drive byte wrong");
  AST_TRK: assert property (ext_on && idx_reg == 3'h2 |-> stat_data[7:2] == {6{!track_valid}} && (!track_valid || stat_data[1:0] == track_num))
    else $error("track byte wrong");
  AST_BLK: assert property (ext_on && idx_reg > 3'h2 |-> stat_data == (idx_reg == 3'h3 ? block_num[15:8] : block_num[7:0]))
    else $error("block byte wrong");
  AST_RST: assert property ($fell(srst) |-> !stat_valid && !stat_busy)
    else $error("busy after reset");
endmodule

// ---- tb/tsr_host_model.sv ----
`timescale 1ns/1ps
module tsr_host_model (
  input  wire        mclk,       // Clock
  input  wire [7:0]  stat_data,  // Byte
  input  wire        stat_valid, // Offered
  input  wire        stat_last,  // Final
  input  wire [3:0]  wait_n,     // Ack delay
  output reg         byte_ack,   // Taken
  output reg  [47:0] shown       // Shown bytes
);
  reg [2:0] n_reg = 3'h0;
  reg [3:0] hold_reg = 4'h0;
  initial byte_ack = 1'b0;
  // Ack held until the taking edge, dropped off it
  always @(negedge mclk)
    if (byte_ack || !stat_valid) begin
      byte_ack <= 1'b0;
      hold_reg <= 4'h0;
    end else if (hold_reg >= wait_n)
      byte_ack <= 1'b1;
    else
      hold_reg <= hold_reg + 4'h1;
  // True reads as zero on display
  always @(posedge mclk)
    if (byte_ack && stat_valid) begin
      shown[n_reg*8 +: 8] <= ~stat_data;
      n_reg <= stat_last ? 3'h0 : n_reg + 3'h1;
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg         mclk = 1'b0, srst = 1'b1, req_pri = 1'b0, req_ext = 1'b0;
  reg  [6:0]  pri0_set = 7'h00, pri1_set = 7'h00, ext0_set = 7'h00;
  reg         data_retry = 1'b0, stream_miss = 1'b0, flags_clr = 1'b0;
  reg         drive0_sel = 1'b0, drive1_sel = 1'b0, track_valid = 1'b0;
  reg  [1:0]  track_num = 2'h0;
  reg  [15:0] block_num = 16'h0000;
  reg  [3:0]  wait_n = 4'h0;
  reg         req_both = 1'b0;
  wire        byte_ack, stat_valid, stat_last, stat_busy;
  wire [7:0]  stat_data;
  wire [47:0] shown;
  integer     err_count = 0, n_checks = 0, i;
  always #50 mclk = ~mclk;
  tsr_top i_tsr_top (.*);
  tsr_host_model i_tsr_host_model (.*);
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task chk_rep(input integer nb, input [47:0] exp);
    for (i = 0; i < nb; i = i + 1)
      chk(shown[i*8 +: 8], ~exp[i*8 +: 8]);
  endtask
  task report(input pri);
    integer k;
    begin
      @(negedge mclk) {req_pri, req_ext} = {pri, !pri | req_both};
      @(negedge mclk) {req_pri, req_ext} = 2'h0;
      for (k = 0; k < 99 && stat_busy !== 1'b0; k = k + 1)
        @(negedge mclk);
      chk({7'h00, stat_busy}, 8'h00);
      @(negedge mclk);
    end
  endtask
  task t_bits;
    integer b;
    for (b = 0; b < 7; b = b + 1) begin
      @(negedge mclk) flags_clr = 1'b1;
      @(negedge mclk) {flags_clr, pri0_set, pri1_set} = {1'b0, 7'h01 << b, 7'h01 << b};
      @(negedge mclk) {pri0_set, pri1_set} = 14'h0000;
      report(1'b1);
      chk_rep(2, {32'h0000_0000, {2{8'h80 | (8'h01 << b)}}});
    end
  endtask
  task t_count;
    begin
      @(negedge mclk) flags_clr = 1'b1;
      @(negedge mclk) {flags_clr, data_retry, stream_miss} = 3'h3;
      @(negedge mclk);
      @(negedge mclk) stream_miss = 1'b0;
      @(negedge mclk) data_retry = 1'b0;
      wait_n = 4'h3;
      report(1'b1);
      chk_rep(6, 48'h0200_0300_0000);
    end
  endtask
  task t_ext;
    begin
      @(negedge mclk) ext0_set = 7'h7f;
      @(negedge mclk) {ext0_set, drive0_sel, track_valid, track_num, block_num} = 27'h00e_1234;
      report(1'b0);
      chk_rep(5, 48'h0034_1202_01fe);
      @(negedge mclk) {flags_clr, drive0_sel, track_valid} = 3'h4;
      @(negedge mclk) flags_clr = 1'b0;
      report(1'b0);
      chk_rep(2, 48'h0000_0000_fc00);
      @(negedge mclk) {drive1_sel, track_valid, track_num} = 4'hf;
      report(1'b0);
      chk_rep(3, 48'h0000_0003_0200);
    end
  endtask
  task t_clash;
    begin
      @(negedge mclk) {flags_clr, pri0_set, data_retry} = {1'b1, 7'h01, 1'b1};
      @(negedge mclk) {flags_clr, pri0_set, data_retry} = 9'h000;
      req_both = 1'b1;
      report(1'b1);
      req_both = 1'b0;
      chk_rep(6, 48'h0000_0100_0081);
    end
  endtask
  task t_reset;
    begin
      @(negedge mclk) srst = 1'b1;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      report(1'b1);
      chk_rep(6, 48'h0000_0000_8100);
    end
  endtask
  task results;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    report(1'b1);
    chk_rep(6, 48'h0000_0000_8100);
    $display("reset test done");
    t_bits;
    $display("bit test done");
    t_count;
    $display("counter test done");
    t_ext;
    $display("extended test done");
    t_clash;
    $display("clash test done");
    t_reset;
    $display("second reset test done");
    results;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    err_count = err_count + 1;
    results;
  end
endmodule
bind tsr_top tsr_properties i_tsr_properties (.*);
